/* File: chain_pkg.sv */
// Shared constants, types and helpers for the post-EQ channel chain
package chain_pkg;

  // Datapath and coefficient widths
  localparam int SAMPLE_W = 26;
  localparam int IN_W = 24;
  localparam int GAIN_W = 22;
  localparam int GAIN_FRAC = 20;
  localparam int PROD_W = 48;

  // Delay limits in samples, input buffer depth in frames
  localparam int DLY_MAX = 165;
  localparam int LA_MAX = 100;
  localparam int IN_FIFO_DEPTH = 16;

  typedef logic signed [SAMPLE_W-1:0] sample_t;
  typedef logic signed [GAIN_W-1:0] gain_t;

  // Gain of 1.0, and the per-frame ramp step (2.0 over 1024 frames)
  localparam gain_t GAIN_ONE = 22'sh100000;
  localparam gain_t VOL_STEP = 22'sh000800;

  // 26-bit saturation limits, in product width
  localparam logic signed [PROD_W-1:0] SAT_HI = 48'sh000001ffffff;
  localparam logic signed [PROD_W-1:0] SAT_LO = 48'shfffffe000000;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_VOL_L = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_VOL_R = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_VOL_S = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SPREAD = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ALPHA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DLY_L = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DLY_R = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_DLY_S = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_LA = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_MAIN_GAIN = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_SUB_GAIN = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_VCUR_L = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_VCUR_R = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_VCUR_S = 8'h3c;

  // Control and status bit positions
  localparam int CTRL_SHUTDOWN = 0;
  localparam int CTRL_MUTE_L = 1;
  localparam int CTRL_MUTE_R = 2;
  localparam int CTRL_MUTE_S = 3;
  localparam int CTRL_TWO_CH = 4;
  localparam int STAT_VOL_ZERO = 0;
  localparam int STAT_BUSY = 1;
  localparam int LEN_W = 8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic signed [IN_W-1:0] l;
    logic signed [IN_W-1:0] r;
    logic signed [IN_W-1:0] s;
  } in_frame_t;

  typedef struct packed {
    sample_t l;
    sample_t r;
    sample_t s;
  } frame_t;

  typedef struct packed {
    logic shutdown;
    logic mute_l;
    logic mute_r;
    logic mute_s;
    logic two_ch;
    gain_t vol_l;
    gain_t vol_r;
    gain_t vol_s;
    gain_t spread;
    gain_t alpha;
    gain_t main_gain;
    gain_t sub_gain;
    logic [LEN_W-1:0] dly_l;
    logic [LEN_W-1:0] dly_r;
    logic [LEN_W-1:0] dly_s;
    logic [LEN_W-1:0] la;
  } cfg_t;

  localparam cfg_t CFG_RST = '{vol_l: GAIN_ONE, vol_r: GAIN_ONE, vol_s: GAIN_ONE,
                               main_gain: GAIN_ONE, sub_gain: GAIN_ONE, default: '0};

  // Frame sequencer, Gray coded along the frame path
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_WIDTH = 3'h1,
    S_VOL = 3'h3,
    S_LA_PUSH = 3'h2,
    S_LA_DRAIN = 3'h6,
    S_DLY_PUSH = 3'h7,
    S_DLY_DRAIN = 3'h5,
    S_OUT = 3'h4
  } state_t;

  // Clip a wide result to the 26-bit datapath, never wrap
  function automatic sample_t sat_w(input logic signed [PROD_W-1:0] v);
    if (v > SAT_HI)
    begin
      return SAT_HI[SAMPLE_W-1:0];
    end
    if (v < SAT_LO)
    begin
      return SAT_LO[SAMPLE_W-1:0];
    end
    return v[SAMPLE_W-1:0];
  endfunction

  function automatic sample_t add_sat(input sample_t a, input sample_t b);
    return sat_w(PROD_W'(a) + PROD_W'(b));
  endfunction

  function automatic sample_t sub_sat(input sample_t a, input sample_t b);
    return sat_w(PROD_W'(a) - PROD_W'(b));
  endfunction

  // Sample times a 2.20 gain
  function automatic sample_t mul_sat(input sample_t a, input gain_t g);
    logic signed [PROD_W-1:0] p;
    p = PROD_W'(a) * PROD_W'(g);
    return sat_w(p >>> GAIN_FRAC);
  endfunction

  // One linear ramp step toward the target; snaps when within a step
  function automatic gain_t vol_ramp(input gain_t cur, input gain_t tgt);
    logic signed [GAIN_W:0] d;
    d = (GAIN_W + 1)'(tgt) - (GAIN_W + 1)'(cur);
    if (d > (GAIN_W + 1)'(VOL_STEP))
    begin
      return cur + VOL_STEP;
    end
    if (d < -((GAIN_W + 1)'(VOL_STEP)))
    begin
      return cur - VOL_STEP;
    end
    return tgt;
  endfunction

  // Merge write data under byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        v[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return v;
  endfunction

endpackage

/* File: sample_fifo.sv */
// FIFO with registered read data and an occupancy count
module sample_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Words held, output register included
  output logic [$clog2(DEPTH+2)-1:0] level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int LW = $clog2(DEPTH + 2);

  if (DEPTH < 1) begin : g_chk
    $error("sample_fifo: DEPTH must be at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic out_valid_d;
  logic push;
  logic load;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Output register refills when empty or being taken
  assign push = in_valid && in_ready;
  assign load = (cnt_q != '0) && (!out_valid || out_ready);
  assign cnt_d = cnt_q + CW'(push) - CW'(load);
  assign out_valid_d = load || (out_valid && !out_ready);

  // Storage write, registered read
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
    if (load)
    begin
      out_data <= mem[rd_q];
    end
  end

  // Pointers, count and flags
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
      level <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= ptr_next(wr_q);
      end
      if (load)
      begin
        rd_q <= ptr_next(rd_q);
      end
      cnt_q <= cnt_d;
      out_valid <= out_valid_d;
      in_ready <= (cnt_d != CW'(DEPTH));
      level <= LW'(cnt_d) + LW'(out_valid_d);
    end
  end

endmodule // sample_fifo

/* File: channel_chain.sv */
// Post-EQ three-channel chain: width, volume, look-ahead, gains, delays
// Notes on behaviour
// - Releasing shutdown ramps each volume back to its setting.
// - Datapath is 26 bits: 24-bit inputs plus two headroom bits.
// - Left, right and sub volumes are independent and always ramp.
// - Volume words are signed 2.20 gains, resetting to exactly 1.0.
// - Ramp rate: 2.0 to zero in 1024 frames, 1.0 in 512.
// - Mute ramps to zero; unmute ramps back to the stored volume.
// - Volume multipliers sit after all biquad sections.
// - Width term is scaled filtered L minus R, added left, subtracted right.
// - Difference passes a first-order low-pass, programmable coefficient.
// - Identical left and right pass the width stage unchanged once the low-passed difference has settled to zero.
// - Each output channel has a programmable delay of up to 165 samples.
// - Left and right get up to 100 look-ahead samples before compressor gain.
// - Two independent compressor gains: one for sub, one for left/right.
// - Two-channel mode mixes processed sub back into left and right.
// - Main compressor gain is applied after the look-ahead delay.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
module channel_chain
  import chain_pkg::*;
#(
  parameter int DLY_DEPTH = DLY_MAX,
  parameter int LA_DEPTH = LA_MAX,
  parameter int IN_DEPTH = IN_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // AXI4-Lite write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Equalized input frames
  input wire logic in_valid,
  output logic in_ready,
  input wire in_frame_t in_frame,
  // Processed output frames
  output logic out_valid,
  input wire logic out_ready,
  output frame_t out_frame
);

  localparam int DLW = $clog2(DLY_DEPTH + 2);
  localparam int LLW = $clog2(LA_DEPTH + 2);

  if (DLY_DEPTH < 1 || DLY_DEPTH > 255) begin : g_chk_dly
    $error("channel_chain: DLY_DEPTH must lie in 1..255");
  end
  if (LA_DEPTH < 1 || LA_DEPTH > 255) begin : g_chk_la
    $error("channel_chain: LA_DEPTH must lie in 1..255");
  end
  if (IN_DEPTH < 2) begin : g_chk_in
    $error("channel_chain: IN_DEPTH must be at least 2");
  end

  cfg_t cfg_q;
  state_t state_q;
  gain_t vcur_l_q;
  gain_t vcur_r_q;
  gain_t vcur_s_q;
  sample_t l_q;
  sample_t r_q;
  sample_t s_q;
  sample_t lp_q;
  sample_t la_l_q;
  sample_t la_r_q;
  sample_t dly_out_q [3];
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] wr_word;
  logic wr_fire;

  in_frame_t fin_data;
  logic fin_valid;
  logic la_valid;
  logic [2*SAMPLE_W-1:0] la_data;
  logic [LLW-1:0] la_level;
  logic la_over;
  logic la_pop;
  sample_t dly_in [3];
  sample_t dly_od [3];
  logic [LEN_W-1:0] dly_len [3];
  logic [DLW-1:0] dly_lvl [3];
  logic [2:0] dly_ov;
  logic [2:0] dly_over;
  logic [2:0] dly_pop;
  sample_t diff;
  sample_t lp_new;
  sample_t wterm;
  sample_t main_l;
  sample_t main_r;

  // Word-aligned register decode
  function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return word_of(a) <= OFF_VCUR_S;
  endfunction

  function automatic logic [LEN_W-1:0] clamp_len(input logic [31:0] v, input int mx);
    return (v > 32'(mx)) ? LEN_W'(mx) : v[LEN_W-1:0];
  endfunction

  // Register readback; unmapped words read zero
  function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (word_of(a))
      OFF_CTRL:
      begin
        v[CTRL_SHUTDOWN] = cfg_q.shutdown;
        v[CTRL_MUTE_L] = cfg_q.mute_l;
        v[CTRL_MUTE_R] = cfg_q.mute_r;
        v[CTRL_MUTE_S] = cfg_q.mute_s;
        v[CTRL_TWO_CH] = cfg_q.two_ch;
      end
      OFF_VOL_L: v[GAIN_W-1:0] = cfg_q.vol_l;
      OFF_VOL_R: v[GAIN_W-1:0] = cfg_q.vol_r;
      OFF_VOL_S: v[GAIN_W-1:0] = cfg_q.vol_s;
      OFF_SPREAD: v[GAIN_W-1:0] = cfg_q.spread;
      OFF_ALPHA: v[GAIN_W-1:0] = cfg_q.alpha;
      OFF_DLY_L: v[LEN_W-1:0] = cfg_q.dly_l;
      OFF_DLY_R: v[LEN_W-1:0] = cfg_q.dly_r;
      OFF_DLY_S: v[LEN_W-1:0] = cfg_q.dly_s;
      OFF_LA: v[LEN_W-1:0] = cfg_q.la;
      OFF_MAIN_GAIN: v[GAIN_W-1:0] = cfg_q.main_gain;
      OFF_SUB_GAIN: v[GAIN_W-1:0] = cfg_q.sub_gain;
      OFF_STATUS:
      begin
        // Host polls the shutdown ramp's end before loading
        v[STAT_VOL_ZERO] = (vcur_l_q == '0) && (vcur_r_q == '0) && (vcur_s_q == '0);
        v[STAT_BUSY] = (state_q != S_IDLE);
      end
      OFF_VCUR_L: v[GAIN_W-1:0] = vcur_l_q;
      OFF_VCUR_R: v[GAIN_W-1:0] = vcur_r_q;
      OFF_VCUR_S: v[GAIN_W-1:0] = vcur_s_q;
    endcase
    return v;
  endfunction

  // Write address, held until the write performs
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b1;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data, taken apart from the address
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_wready <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= reg_read(s_axi_araddr);
      s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Strobed merge with current contents
  always_comb
  begin
    wr_word = apply_strb(reg_read(aw_addr_q), w_data_q, w_strb_q);
  end

  // Config registers; status words ignore writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_q <= CFG_RST;
    end
    else if (wr_fire)
    begin
      case (word_of(aw_addr_q))
        OFF_CTRL:
        begin
          cfg_q.shutdown <= wr_word[CTRL_SHUTDOWN];
          cfg_q.mute_l <= wr_word[CTRL_MUTE_L];
          cfg_q.mute_r <= wr_word[CTRL_MUTE_R];
          cfg_q.mute_s <= wr_word[CTRL_MUTE_S];
          cfg_q.two_ch <= wr_word[CTRL_TWO_CH];
        end
        OFF_VOL_L: cfg_q.vol_l <= wr_word[GAIN_W-1:0];
        OFF_VOL_R: cfg_q.vol_r <= wr_word[GAIN_W-1:0];
        OFF_VOL_S: cfg_q.vol_s <= wr_word[GAIN_W-1:0];
        OFF_SPREAD: cfg_q.spread <= wr_word[GAIN_W-1:0];
        OFF_ALPHA: cfg_q.alpha <= wr_word[GAIN_W-1:0];
        // Over-long lengths clamp, not wrap
        OFF_DLY_L: cfg_q.dly_l <= clamp_len(wr_word, DLY_DEPTH);
        OFF_DLY_R: cfg_q.dly_r <= clamp_len(wr_word, DLY_DEPTH);
        OFF_DLY_S: cfg_q.dly_s <= clamp_len(wr_word, DLY_DEPTH);
        OFF_LA: cfg_q.la <= clamp_len(wr_word, LA_DEPTH);
        OFF_MAIN_GAIN: cfg_q.main_gain <= wr_word[GAIN_W-1:0];
        OFF_SUB_GAIN: cfg_q.sub_gain <= wr_word[GAIN_W-1:0];
        default: ;
      endcase
    end
  end

  // Volume ramps a step per frame; mute and shutdown only move the target
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      vcur_l_q <= GAIN_ONE;
      vcur_r_q <= GAIN_ONE;
      vcur_s_q <= GAIN_ONE;
    end
    else if (state_q == S_WIDTH)
    begin
      vcur_l_q <= vol_ramp(vcur_l_q, (cfg_q.shutdown || cfg_q.mute_l) ? '0 : cfg_q.vol_l);
      vcur_r_q <= vol_ramp(vcur_r_q, (cfg_q.shutdown || cfg_q.mute_r) ? '0 : cfg_q.vol_r);
      vcur_s_q <= vol_ramp(vcur_s_q, (cfg_q.shutdown || cfg_q.mute_s) ? '0 : cfg_q.vol_s);
    end
  end

  // Input frame buffer, whose ready is the block's
  sample_fifo #(
    .WIDTH($bits(in_frame_t)),
    .DEPTH(IN_DEPTH)
  ) u_in_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_frame),
    .out_valid(fin_valid),
    .out_ready(state_q == S_IDLE),
    .out_data(fin_data),
    .level()
  );

  // Width expander: low-passed difference, scaled
  always_comb
  begin
    diff = sub_sat(l_q, r_q);
    lp_new = add_sat(lp_q, mul_sat(sub_sat(diff, lp_q), cfg_q.alpha));
    wterm = mul_sat(lp_new, cfg_q.spread);
  end

  // Look-ahead on left and right only, ahead of the main gain
  assign la_valid = (state_q == S_LA_PUSH);
  assign la_over = int'(la_level) > int'(cfg_q.la);
  sample_fifo #(
    .WIDTH(2 * SAMPLE_W),
    .DEPTH(LA_DEPTH)
  ) u_la_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(la_valid),
    .in_ready(),
    .in_data({l_q, r_q}),
    .out_valid(la_pop),
    .out_ready((state_q == S_LA_DRAIN) && la_over),
    .out_data(la_data),
    .level(la_level)
  );

  // Look-ahead output; silence while the line fills
  always_ff @(posedge clk)
  begin
    if (srst || la_valid)
    begin
      la_l_q <= '0;
      la_r_q <= '0;
    end
    else if ((state_q == S_LA_DRAIN) && la_over && la_pop)
    begin
      la_l_q <= la_data[2*SAMPLE_W-1:SAMPLE_W];
      la_r_q <= la_data[SAMPLE_W-1:0];
    end
  end

  // Main compressor gain, then optional sub mix
  assign main_l = mul_sat(la_l_q, cfg_q.main_gain);
  assign main_r = mul_sat(la_r_q, cfg_q.main_gain);

  // Per-channel output delay lines
  assign dly_in[0] = l_q;
  assign dly_in[1] = r_q;
  assign dly_in[2] = s_q;
  assign dly_len[0] = cfg_q.dly_l;
  assign dly_len[1] = cfg_q.dly_r;
  assign dly_len[2] = cfg_q.dly_s;
  for (genvar i = 0; i < 3; i++) begin : g_dly
    assign dly_over[i] = int'(dly_lvl[i]) > int'(dly_len[i]);
    assign dly_pop[i] = (state_q == S_DLY_DRAIN) && dly_ov[i] && dly_over[i];
    sample_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(DLY_DEPTH)
    ) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(state_q == S_DLY_PUSH),
      .in_ready(),
      .in_data(dly_in[i]),
      .out_valid(dly_ov[i]),
      .out_ready(dly_pop[i]),
      .out_data(dly_od[i]),
      .level(dly_lvl[i])
    );
  end

  // Delay outputs; a shortened delay keeps the newest pop
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (srst || (state_q == S_DLY_PUSH))
      begin
        dly_out_q[i] <= '0;
      end
      else if (dly_pop[i])
      begin
        dly_out_q[i] <= dly_od[i];
      end
    end
  end

  // Frame sequencer and working samples
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= S_IDLE;
      l_q <= '0;
      r_q <= '0;
      s_q <= '0;
      lp_q <= '0;
    end
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          if (fin_valid)
          begin
            l_q <= SAMPLE_W'(fin_data.l);
            r_q <= SAMPLE_W'(fin_data.r);
            s_q <= SAMPLE_W'(fin_data.s);
            state_q <= S_WIDTH;
          end
        end
        S_WIDTH:
        begin
          lp_q <= lp_new;
          l_q <= add_sat(l_q, wterm);
          r_q <= sub_sat(r_q, wterm);
          state_q <= S_VOL;
        end
        S_VOL:
        begin
          // Input is already past every biquad stage
          l_q <= mul_sat(l_q, vcur_l_q);
          r_q <= mul_sat(r_q, vcur_r_q);
          s_q <= mul_sat(s_q, vcur_s_q);
          state_q <= S_LA_PUSH;
        end
        S_LA_PUSH:
        begin
          s_q <= mul_sat(s_q, cfg_q.sub_gain);
          state_q <= S_LA_DRAIN;
        end
        S_LA_DRAIN:
        begin
          if (!la_over)
          begin
            l_q <= cfg_q.two_ch ? add_sat(main_l, s_q) : main_l;
            r_q <= cfg_q.two_ch ? add_sat(main_r, s_q) : main_r;
            state_q <= S_DLY_PUSH;
          end
        end
        S_DLY_PUSH: state_q <= S_DLY_DRAIN;
        S_DLY_DRAIN:
        begin
          if (dly_over == '0)
          begin
            state_q <= S_OUT;
          end
        end
        S_OUT:
        begin
          // A stalled output holds the sequencer; input buffer fills
          if (!out_valid || out_ready)
          begin
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Output frame register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
      out_frame <= '0;
    end
    else if ((state_q == S_OUT) && (!out_valid || out_ready))
    begin
      out_valid <= 1'b1;
      out_frame <= '{l: dly_out_q[0], r: dly_out_q[1], s: dly_out_q[2]};
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule // channel_chain

/* File: chain_checker.sv */
// Read-bus and output-stream assertions
module chain_checker
  import chain_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire frame_t out_frame
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Read answer a cycle after the address
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed");
  // Unmapped words: error, zero data
  AST_BAD_ADDR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h3f
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read");
  AST_OK_ADDR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h40
    |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  // Upper bits above 22 read zero
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:22] == 10'h0)
    else $error("upper bits set");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_frame))
    else $error("frame moved");
  AST_RST: assert property ($past(srst) |-> !out_valid && !s_axi_rvalid)
    else $error("reset state");
endmodule // chain_checker

bind channel_chain chain_checker i_chain_checker (.*);

/* File: chain_host.sv */
// Host model driving the register bus
module chain_host (
  // Clock
  input wire logic clk,
  // Write channels
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr = 8'h00,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0] s_axi_wstrb = 4'hf,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  // Read channels
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr = 8'h00,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Late rready: slave must hold its answer
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule // chain_host

/* File: audio_post_eq_channel_chain_test.sv */
// Self-checking bench for the channel chain
module audio_post_eq_channel_chain_test
  import chain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic in_valid = 1'b0;
  logic out_ready = 1'b0;
  logic in_ready, out_valid, stall = 1'b0;
  in_frame_t in_frame = '0;
  frame_t out_frame;
  int fails = 0;
  int compares = 0;
  int seed = 91558;
  logic [33:0] rq[$];
  frame_t fq[$];
  gain_t g[3] = '{default: GAIN_ONE};
  gain_t v[3] = '{default: GAIN_ONE};
  logic [3:0] c = 4'h0;
  channel_chain i_channel_chain (.*);
  chain_host i_chain_host (.*);
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [77:0] e, s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Oldest note against each answer; random output stalls
  always @(posedge clk)
  begin
    out_ready <= !stall && 1'($random(seed));
    if (s_axi_rvalid && s_axi_rready)
      chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", RESP_OKAY, s_axi_bresp);
    if (out_valid && out_ready)
      chk("frame", fq.pop_front(), out_frame);
  end
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    i_chain_host.rd(a);
  endtask
  task automatic push(input in_frame_t f, input frame_t e);
    fq.push_back(e);
    @(posedge clk);
    in_frame <= f;
    in_valid <= 1'b1;
    do @(posedge clk); while (!in_ready);
    in_valid <= 1'b0;
  endtask
  // Let frames in flight finish before config changes
  task automatic idle();
    while (fq.size() > 0) @(posedge clk);
  endtask
  function automatic gain_t step(input gain_t a, t);
    if (t > a + VOL_STEP)
      return a + VOL_STEP;
    if (t < a - VOL_STEP)
      return a - VOL_STEP;
    return t;
  endfunction
  // Unit input: outputs equal the ramped gain
  task automatic rf(input int n);
    repeat (n)
    begin
      for (int k = 0; k < 3; k++)
        g[k] = step(g[k], (c[0] || c[k+1]) ? 22'sh0 : v[k]);
      push({3{24'h100000}}, {sample_t'(g[0]), sample_t'(g[1]), sample_t'(g[2])});
    end
    idle();
  endtask
  function automatic in_frame_t cf();
    logic [23:0] x;
    x = 24'($random(seed));
    return {x, x, 24'($random(seed))};
  endfunction
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(OFF_VOL_L, {RESP_OKAY, 32'h100000});
    rd(OFF_VCUR_S, {RESP_OKAY, 32'h100000});
    rd(8'h40, {RESP_SLVERR, 32'h0});
    i_chain_host.wr(OFF_SPREAD, 32'h00100000);
    i_chain_host.wr(OFF_ALPHA, 32'h00100000);
    $display("test registers done");
    // Centre frames into a stalled chain
    stall <= 1'b1;
    in_frame <= cf();
    in_valid <= 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (in_ready)
      begin
        fq.push_back({sample_t'(in_frame.l), sample_t'(in_frame.r), sample_t'(in_frame.s)});
        in_frame <= cf();
      end
    end
    chk("in_ready", 78'h0, 78'(in_ready));
    in_valid <= 1'b0;
    stall <= 1'b0;
    idle();
    push({24'h400000, 48'h0}, {26'h0800000, 26'h3c00000, 26'h0});
    idle();
    $display("test width done");
    v[0] = '0;
    i_chain_host.wr(OFF_VOL_L, 32'h0);
    rf(512);
    rd(OFF_VCUR_L, {RESP_OKAY, 32'h0});
    c = 4'h1;
    i_chain_host.wr(OFF_CTRL, 32'h1);
    rf(3);
    c = 4'h4;
    i_chain_host.wr(OFF_CTRL, 32'h4);
    rf(3);
    c = 4'h0;
    i_chain_host.wr(OFF_CTRL, 32'h0);
    rf(4);
    $display("test volume done");
    test_done();
  end
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule // audio_post_eq_channel_chain_test
